/* scp_serial_config.sv */
// Summary of operation
// - Configuration register resets to 02h, reserved zero
// - Bank enable clear blocks extended bank access
// - Bank enable set permits bank switching
// - Bit 2 is read-only transfer busy
// - Low power active stops clock, defaults outputs
// - Low power ring input can still interrupt
// - Low power keeps registers; inactive blocks access
// - Normal power active runs clock, full function
// - Float bit with inactive device floats outputs
// - Infrared transmit low whenever infrared inactive
// - Base high resets 03h, bits 7-3 zero
// - Base low resets F8h, bits 2-0 zero
// - Interrupt type only bit 1 writable, 03h
// - Both DMA reports read-only 04h
// - Interrupt number holds wake enable, 04h
// - Activation register read-write, resets 00h
// - Inactive device blocks runtime register access
// - Port one config shares port two layout
`include "scp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module scp_serial_config
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port status (index 0 port one, 1 port two)
   input wire logic portTwoActive,
   input wire logic [1:0] transferBusy,
   input wire logic [1:0] uartTxIn,
   input wire logic ringIndicatorIn,
   input wire logic irActive,
   input wire logic irTxIn,
   // Port controls
   output logic [1:0] portClkEn,
   output logic [1:0] runtimeAccessEn,
   output logic [1:0] bankAccessEn,
   output logic [1:0] serialTxOut,
   output logic [1:0] serialTxOe,
   output logic infraredTransmitOut,
   output logic ringWakeIrq
);

   ////////////////////////////////////////////////////////////////////////
   // Storage

   logic [7:0] activateQ; // Port one activation
   logic [2:0] baseHighQ; // Writable base high bits
   logic [4:0] baseLowQ; // Writable base low bits
   logic [7:0] irqNumberQ; // Interrupt number and wake enable
   logic irqTypeQ; // Only writable interrupt type bit
   scp_pkg::scp_cfg_s cfgQ [2]; // Port configuration bits
   logic [31:0] prdataQ; // Read data register
   logic preadyQ; // Access phase answer
   logic pslverrQ; // Unmapped address answer
   logic [1:0] portActive; // Activation of each port
   scp_pkg::scp_reg_e selNow; // Decoded register
   logic wrTake; // Write takes effect this edge
   logic [7:0] wbyte; // Written byte

   // Decode of a word address into a register
   function automatic scp_pkg::scp_reg_e decodeReg(input logic [11:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      case (idx)
         `SCP_IDX_ACTIVATE: decodeReg = scp_pkg::REG_ACTIVATE;
         `SCP_IDX_BASE_HIGH: decodeReg = scp_pkg::REG_BASE_HIGH;
         `SCP_IDX_BASE_LOW: decodeReg = scp_pkg::REG_BASE_LOW;
         `SCP_IDX_IRQ_NUMBER: decodeReg = scp_pkg::REG_IRQ_NUMBER;
         `SCP_IDX_IRQ_TYPE: decodeReg = scp_pkg::REG_IRQ_TYPE;
         `SCP_IDX_DMA_A: decodeReg = scp_pkg::REG_DMA;
         `SCP_IDX_DMA_B: decodeReg = scp_pkg::REG_DMA;
         `SCP_IDX_ONE_CONFIG: decodeReg = scp_pkg::REG_ONE_CONFIG;
         `SCP_IDX_TWO_CONFIG: decodeReg = scp_pkg::REG_TWO_CONFIG;
         default: decodeReg = scp_pkg::REG_NONE;
      endcase
   endfunction

   // Layout shared by both config registers, busy from live input
   function automatic logic [7:0] cfgByte(input scp_pkg::scp_cfg_s c, input logic busy);
      logic [7:0] v;
      v = 8'h00; // Reserved bits read zero
      v[`SCP_CFG_BANK_BIT] = c.bankEnable;
      v[`SCP_CFG_BUSY_BIT] = busy;
      v[`SCP_CFG_POWER_BIT] = c.powerNormal;
      v[`SCP_CFG_FLOAT_BIT] = c.floatInactive;
      cfgByte = v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   always_comb
   begin
      selNow = decodeReg(paddr);
      wrTake = psel && penable && preadyQ && pwrite && !pslverrQ;
      wbyte = pwdata[7:0];
      portActive = {portTwoActive, activateQ[`SCP_ACT_BIT]};
   end

   // Answer in the first access cycle, so each transfer takes two cycles
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         preadyQ <= 1'b0;
         pslverrQ <= 1'b0;
      end
      else
      begin
         preadyQ <= psel && !penable;
         pslverrQ <= psel && !penable && (selNow == scp_pkg::REG_NONE);
      end
   end

   // Read data captured at the setup edge; registers stay readable
   // in low power mode
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         prdataQ <= 32'h0000_0000;
      end
      else if (psel && !penable && !pwrite)
      begin
         case (selNow)
            scp_pkg::REG_ACTIVATE: prdataQ <= {24'h000000, activateQ};
            scp_pkg::REG_BASE_HIGH: prdataQ <= {27'h0000000, 2'h0, baseHighQ};
            scp_pkg::REG_BASE_LOW: prdataQ <= {24'h000000, baseLowQ, 3'h0};
            scp_pkg::REG_IRQ_NUMBER: prdataQ <= {24'h000000, irqNumberQ};
            scp_pkg::REG_IRQ_TYPE: prdataQ <= {24'h000000, 6'h00, irqTypeQ, 1'b1};
            scp_pkg::REG_DMA: prdataQ <= {24'h000000, `SCP_RST_DMA};
            scp_pkg::REG_ONE_CONFIG: prdataQ <= {24'h000000, cfgByte(cfgQ[0], transferBusy[0])};
            scp_pkg::REG_TWO_CONFIG: prdataQ <= {24'h000000, cfgByte(cfgQ[1], transferBusy[1])};
            default: prdataQ <= 32'h0000_0000; // Unmapped reads zero
         endcase
      end
      else if (!psel)
      begin
         prdataQ <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes

   // Activation, base, interrupt number and type of port one
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         activateQ <= `SCP_RST_ACTIVATE;
         baseHighQ <= 3'(`SCP_RST_BASE_HIGH);
         baseLowQ <= 5'(`SCP_RST_BASE_LOW >> 3);
         irqNumberQ <= `SCP_RST_IRQ_NUMBER;
         irqTypeQ <= 1'(`SCP_RST_IRQ_TYPE >> `SCP_IRQ_TYPE_RW_BIT);
      end
      else if (wrTake)
      begin
         case (selNow)
            scp_pkg::REG_ACTIVATE: activateQ <= wbyte;
            scp_pkg::REG_BASE_HIGH: baseHighQ <= wbyte[2:0];
            scp_pkg::REG_BASE_LOW: baseLowQ <= wbyte[7:3];
            scp_pkg::REG_IRQ_NUMBER: irqNumberQ <= wbyte;
            scp_pkg::REG_IRQ_TYPE: irqTypeQ <= wbyte[`SCP_IRQ_TYPE_RW_BIT];
            default: ; // DMA reports and others ignore writes
         endcase
      end
   end

   // Config registers; busy and reserved bits have no storage
   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_cfg
         localparam scp_pkg::scp_reg_e MYREG = (p == 0) ? scp_pkg::REG_ONE_CONFIG : scp_pkg::REG_TWO_CONFIG;
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               cfgQ[p].bankEnable <= 1'(`SCP_RST_CONFIG >> `SCP_CFG_BANK_BIT);
               cfgQ[p].powerNormal <= 1'(`SCP_RST_CONFIG >> `SCP_CFG_POWER_BIT);
               cfgQ[p].floatInactive <= 1'(`SCP_RST_CONFIG >> `SCP_CFG_FLOAT_BIT);
            end
            else if (wrTake && selNow == MYREG)
            begin
               cfgQ[p].bankEnable <= wbyte[`SCP_CFG_BANK_BIT];
               cfgQ[p].powerNormal <= wbyte[`SCP_CFG_POWER_BIT];
               cfgQ[p].floatInactive <= wbyte[`SCP_CFG_FLOAT_BIT]; // Busy write dropped
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Port control outputs

   logic [1:0] clkEnQ; // Port clock gate
   logic [1:0] runAccQ; // Runtime register access
   logic [1:0] bankAccQ; // Extended bank access
   logic [1:0] txQ; // Serial output level
   logic [1:0] txOeQ; // Serial output enable

   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_port
         // Access permits follow activation and bank enable
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               runAccQ[p] <= 1'b0;
               bankAccQ[p] <= 1'b0;
            end
            else
            begin
               runAccQ[p] <= portActive[p];
               bankAccQ[p] <= portActive[p] && cfgQ[p].bankEnable;
            end
         end

         // Clock and pin state per power mode
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               clkEnQ[p] <= 1'b0;
               txQ[p] <= 1'b1;
               txOeQ[p] <= 1'b1;
            end
            else if (!portActive[p])
            begin
               clkEnQ[p] <= 1'b0;
               txQ[p] <= 1'b1;
               txOeQ[p] <= !cfgQ[p].floatInactive;
            end
            else if (!cfgQ[p].powerNormal)
            begin
               // Low power: idle mark level, clock stopped
               clkEnQ[p] <= 1'b0;
               txQ[p] <= 1'b1;
               txOeQ[p] <= 1'b1;
            end
            else
            begin
               clkEnQ[p] <= 1'b1;
               txQ[p] <= uartTxIn[p];
               txOeQ[p] <= 1'b1;
            end
         end
      end
   endgenerate

   // Infrared pin always driven, forced low unless infrared runs
   logic irOutQ; // Infrared output level
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         irOutQ <= 1'b0;
      end
      else
      begin
         irOutQ <= irActive && portActive[1] && cfgQ[1].powerNormal && irTxIn;
      end
   end

   // Ring wake only matters in low power; normal mode uses the UART path
   logic ringIrqQ; // Ring wake request
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ringIrqQ <= 1'b0;
      end
      else
      begin
         ringIrqQ <= portActive[0] && !cfgQ[0].powerNormal
                     && irqNumberQ[`SCP_IRQ_WAKE_BIT] && ringIndicatorIn;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = prdataQ;
   assign pready = preadyQ;
   assign pslverr = pslverrQ;
   assign portClkEn = clkEnQ;
   assign runtimeAccessEn = runAccQ;
   assign bankAccessEn = bankAccQ;
   assign serialTxOut = txQ;
   assign serialTxOe = txOeQ;
   assign infraredTransmitOut = irOutQ;
   assign ringWakeIrq = ringIrqQ;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic setupRead; // Setup cycle of a read
   assign setupRead = psel && !penable && !pwrite;

   // Reset values, judged even while reset is held
   AST_CFG_RESET: assert property (disable iff (1'b0) rst
      |=> cfgByte(cfgQ[0], 1'b0) == `SCP_RST_CONFIG && cfgByte(cfgQ[1], 1'b0) == `SCP_RST_CONFIG)
      else $error("config reset value wrong");
   AST_ACT_RESET: assert property (disable iff (1'b0) rst |=> activateQ == `SCP_RST_ACTIVATE)
      else $error("activation reset value wrong");
   AST_NUM_RESET: assert property (disable iff (1'b0) rst |=> irqNumberQ == `SCP_RST_IRQ_NUMBER)
      else $error("interrupt number reset value wrong");
   // Bank gates of both ports
   AST_BANK_BLOCK: assert property (!cfgQ[1].bankEnable |=> !bankAccQ[1])
      else $error("bank access without enable");
   AST_BANK_BLOCK_ONE: assert property (!cfgQ[0].bankEnable |=> !bankAccQ[0])
      else $error("port one bank access without enable");
   AST_BANK_OPEN: assert property (cfgQ[0].bankEnable && portActive[0] |=> bankAccQ[0])
      else $error("bank access not granted");
   AST_BUSY_READ: assert property (setupRead && selNow == scp_pkg::REG_ONE_CONFIG
      |=> prdataQ[`SCP_CFG_BUSY_BIT] == $past(transferBusy[0]))
      else $error("busy bit does not follow transfer");
   AST_ONE_LAYOUT: assert property (setupRead && selNow == scp_pkg::REG_ONE_CONFIG
      |=> prdataQ[6:3] == 4'h0 && prdataQ[`SCP_CFG_BANK_BIT] == $past(cfgQ[0].bankEnable))
      else $error("port one config layout wrong");
   // Power modes; an attempt launched on the last reset edge escapes the
   // disable, so the low power and normal checks also ask that reset was low when they start
   AST_LOW_POWER: assert property (!rst && portActive[0] && !cfgQ[0].powerNormal
      |=> !clkEnQ[0] && txQ[0] && txOeQ[0])
      else $error("low power port not stopped");
   AST_LOW_ACCESS: assert property (!rst && portActive[0] && !cfgQ[0].powerNormal |=> runAccQ[0])
      else $error("low power port lost register access");
   AST_NORMAL: assert property (!rst && portActive[1] && cfgQ[1].powerNormal
      |=> clkEnQ[1] && txQ[1] == $past(uartTxIn[1]))
      else $error("normal power port not running");
   AST_FLOAT: assert property (!portActive[0] && cfgQ[0].floatInactive |=> !txOeQ[0])
      else $error("inactive port not floated");
   AST_IR_LOW: assert property (!irActive |=> !irOutQ)
      else $error("infrared output not low");
   AST_RING: assert property (portActive[0] && !cfgQ[0].powerNormal && irqNumberQ[`SCP_IRQ_WAKE_BIT]
      && ringIndicatorIn |=> ringIrqQ)
      else $error("ring wake missed");
   // Read layouts of the fixed and partly fixed registers
   AST_BASE_READ: assert property (setupRead && selNow == scp_pkg::REG_BASE_LOW
      |=> prdataQ[2:0] == 3'h0 ##1 !pready)
      else $error("base low alignment bits set");
   AST_BASE_HIGH_READ: assert property (setupRead && selNow == scp_pkg::REG_BASE_HIGH
      |=> prdataQ[7:3] == 5'h00)
      else $error("base high upper bits set");
   AST_DMA: assert property (setupRead && selNow == scp_pkg::REG_DMA |=> prdataQ == 32'h0000_0004)
      else $error("dma report wrong");
   AST_TYPE: assert property (setupRead && selNow == scp_pkg::REG_IRQ_TYPE
      |=> prdataQ[0] && prdataQ[7:2] == 6'h00)
      else $error("interrupt type read-only bits wrong");
   // Inactive port one keeps the host out of its runtime registers
   AST_RUNTIME: assert property (!portActive[0] |=> !runAccQ[0])
      else $error("runtime access while inactive");

   COV_WRITE_CFG: cover property (wrTake && selNow == scp_pkg::REG_TWO_CONFIG);
   COV_LOW_POWER: cover property (portActive[0] && !cfgQ[0].powerNormal ##1 ringIrqQ);
   COV_FLOAT: cover property (!txOeQ[0]);
   COV_UNMAPPED: cover property (pslverrQ && pready);

endmodule

`default_nettype wire

/* scp_consts.svh */
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// Register indexes (byte address is four times the index)
`define SCP_IDX_ACTIVATE 10'h030
`define SCP_IDX_BASE_HIGH 10'h060
`define SCP_IDX_BASE_LOW 10'h061
`define SCP_IDX_IRQ_NUMBER 10'h070
`define SCP_IDX_IRQ_TYPE 10'h071
`define SCP_IDX_DMA_A 10'h074
`define SCP_IDX_DMA_B 10'h075
`define SCP_IDX_ONE_CONFIG 10'h0F0
`define SCP_IDX_TWO_CONFIG 10'h1F0

// Reset values
`define SCP_RST_ACTIVATE 8'h00
`define SCP_RST_BASE_HIGH 8'h03
`define SCP_RST_BASE_LOW 8'hF8
`define SCP_RST_IRQ_NUMBER 8'h04
`define SCP_RST_IRQ_TYPE 8'h03
`define SCP_RST_DMA 8'h04
`define SCP_RST_CONFIG 8'h02

// Configuration register field positions
`define SCP_CFG_BANK_BIT 7
`define SCP_CFG_BUSY_BIT 2
`define SCP_CFG_POWER_BIT 1
`define SCP_CFG_FLOAT_BIT 0

// Other field positions
`define SCP_IRQ_TYPE_RW_BIT 1
`define SCP_IRQ_WAKE_BIT 4
`define SCP_ACT_BIT 0

`endif

/* scp_pkg.sv */
package scp_pkg;

   // Register selected by an APB address
   typedef enum logic [3:0]
   {
      REG_NONE = 4'h0,
      REG_ACTIVATE = 4'h1,
      REG_BASE_HIGH = 4'h2,
      REG_BASE_LOW = 4'h3,
      REG_IRQ_NUMBER = 4'h4,
      REG_IRQ_TYPE = 4'h5,
      REG_DMA = 4'h6,
      REG_ONE_CONFIG = 4'h7,
      REG_TWO_CONFIG = 4'h8
   } scp_reg_e;

   // Writable bits of a port configuration register
   typedef struct packed
   {
      logic bankEnable;
      logic powerNormal;
      logic floatInactive;
   } scp_cfg_s;

endpackage

/* test_serial_port_config_registers.sv */
`include "scp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module test_serial_port_config_registers;

////////////////////////////////////////////////////////////////////////
// Stimulus and observed signals
logic sys_clk = 1'b0;
logic rst = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata;
logic pready, pslverr, infraredTransmitOut, ringWakeIrq;
logic portTwoActive = 1'b0;
logic ringIndicatorIn = 1'b0;
logic irActive = 1'b0;
logic irTxIn = 1'b0;
logic [1:0] transferBusy = 2'h0;
logic [1:0] uartTxIn = 2'h0;
logic [1:0] portClkEn, runtimeAccessEn, bankAccessEn, serialTxOut, serialTxOe;
// Counters and reference model state
int failCount = 0;
int totalChecks = 0;
int cycles = 0;
int actv, bh, bl, irqn, irqt;
int cfg[2];
logic [31:0] rd;
logic er;
// Last entry is unmapped on purpose
logic [9:0] idxs[10] = '{`SCP_IDX_ACTIVATE, `SCP_IDX_BASE_HIGH, `SCP_IDX_BASE_LOW,
   `SCP_IDX_IRQ_NUMBER, `SCP_IDX_IRQ_TYPE, `SCP_IDX_DMA_A, `SCP_IDX_DMA_B,
   `SCP_IDX_ONE_CONFIG, `SCP_IDX_TWO_CONFIG, 10'h2A5};

scp_serial_config dut
(
   .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .portTwoActive, .transferBusy, .uartTxIn, .ringIndicatorIn,
   .irActive, .irTxIn, .portClkEn, .runtimeAccessEn, .bankAccessEn,
   .serialTxOut, .serialTxOe, .infraredTransmitOut, .ringWakeIrq
);

// Free-running 40 MHz clock
always #12.5 sys_clk = ~sys_clk;

////////////////////////////////////////////////////////////////////////
// Verdict, shared by the main flow and the hang guard
task automatic tally_and_finish();
   $display("checks %0d mismatches %0d", totalChecks, failCount);
   if (failCount == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
   else
      $display("MISMATCHES SEEN");
   $finish;
endtask

// Hang guard, far above the roughly one thousand cycles expected
always @(posedge sys_clk)
begin
   cycles++;
   if (cycles == 20000)
   begin
      failCount++;
      tally_and_finish();
   end
end

// Compare register results
task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
   totalChecks++;
   if (got !== exp)
   begin
      failCount++;
      $display("unexpected data at %0t: got %0h exp %0h", $time, got, exp);
   end
endtask

// Compare pin results
task automatic check_pin(input logic got, input logic exp);
   totalChecks++;
   if (got !== exp)
   begin
      failCount++;
      $display("unexpected pin at %0t: got %0h exp %0h", $time, got, exp);
   end
endtask

////////////////////////////////////////////////////////////////////////
// Reference register model
function automatic logic [31:0] model_rd(input logic [9:0] i);
   case (i)
      `SCP_IDX_ACTIVATE: return actv;
      `SCP_IDX_BASE_HIGH: return bh;
      `SCP_IDX_BASE_LOW: return bl;
      `SCP_IDX_IRQ_NUMBER: return irqn;
      `SCP_IDX_IRQ_TYPE: return irqt;
      `SCP_IDX_DMA_A, `SCP_IDX_DMA_B: return 32'h04;
      // Busy reads back live, never stored
      `SCP_IDX_ONE_CONFIG: return cfg[0] | {transferBusy[0], 2'b00};
      `SCP_IDX_TWO_CONFIG: return cfg[1] | {transferBusy[1], 2'b00};
      default: return 32'h0;
   endcase
endfunction

// Only documented writable bits land in the model
function automatic void model_wr(input logic [9:0] i, input logic [31:0] d);
   case (i)
      `SCP_IDX_ACTIVATE: actv = d[7:0];
      `SCP_IDX_BASE_HIGH: bh = d & 32'h07;
      `SCP_IDX_BASE_LOW: bl = d & 32'hF8;
      `SCP_IDX_IRQ_NUMBER: irqn = d[7:0];
      `SCP_IDX_IRQ_TYPE: irqt = (d & 32'h02) | 32'h01;
      `SCP_IDX_ONE_CONFIG: cfg[0] = d & 32'h83;
      `SCP_IDX_TWO_CONFIG: cfg[1] = d & 32'h83;
      default: ;
   endcase
endfunction

////////////////////////////////////////////////////////////////////////
// Synchronous reset for 6 cycles, model back to reset values
task automatic do_reset();
   rst <= 1'b1;
   repeat (6) @(posedge sys_clk);
   rst <= 1'b0;
   actv = 0;
   bh = 32'h03;
   bl = 32'hF8;
   irqn = 32'h04;
   irqt = 32'h03;
   cfg = '{32'h02, 32'h02};
endtask

// One APB transfer; request held until pready is sampled high
task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
   @(posedge sys_clk);
   psel <= 1'b1;
   pwrite <= wr;
   paddr <= {idx, 2'b00};
   pwdata <= d;
   @(posedge sys_clk);
   penable <= 1'b1;
   do @(posedge sys_clk); while (pready !== 1'b1);
   rd = prdata;
   er = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
endtask

// Transfer plus model comparison
task automatic access(input logic wr, input logic [9:0] idx, input logic [31:0] d);
   logic bad;
   bad = 1'b1;
   foreach (idxs[k])
      if (k < 9 && idxs[k] == idx)
         bad = 1'b0;
   apb(wr, idx, d);
   check_data({31'h0, er}, {31'h0, bad});
   if (wr)
      model_wr(idx, d);
   else
      check_data(rd, model_rd(idx));
endtask

// Pins after the one-clock lag has passed
task automatic pins();
   logic a, pn;
   repeat (3) @(posedge sys_clk);
   for (int i = 0; i < 2; i++)
   begin
      a = (i == 1) ? portTwoActive : actv[0];
      pn = cfg[i][1];
      check_pin(portClkEn[i], a & pn);
      check_pin(runtimeAccessEn[i], a);
      // Inactive ports hold the bank gate shut and the output at mark
      check_pin(bankAccessEn[i], a & cfg[i][7]);
      check_pin(serialTxOut[i], (a & pn) ? uartTxIn[i] : 1'b1);
      check_pin(serialTxOe[i], a | ~cfg[i][0]);
   end
   check_pin(infraredTransmitOut, irActive & portTwoActive & cfg[1][1] & irTxIn);
   check_pin(ringWakeIrq, actv[0] & ~cfg[0][1] & irqn[4] & ringIndicatorIn);
endtask

////////////////////////////////////////////////////////////////////////
// Main sequence
initial
begin
   void'($urandom(32'h848933B1));
   do_reset();
   foreach (idxs[k])
      access(1'b0, idxs[k], 32'h0);
   pins();
   $display("test reset values done");
   // Random writes everywhere, read-only and reserved bits included
   repeat (4)
   begin
      transferBusy <= 2'($urandom);
      foreach (idxs[k])
         access(1'b1, idxs[k], $urandom);
      foreach (idxs[k])
         access(1'b0, idxs[k], 32'h0);
   end
   $display("test register access done");
   // Random power, float, bank and activity mixes
   repeat (40)
   begin
      {portTwoActive, ringIndicatorIn, irActive, irTxIn, uartTxIn} <= 6'($urandom);
      access(1'b1, `SCP_IDX_ACTIVATE, 32'($urandom & 1));
      access(1'b1, `SCP_IDX_ONE_CONFIG, $urandom);
      access(1'b1, `SCP_IDX_TWO_CONFIG, $urandom);
      access(1'b1, `SCP_IDX_IRQ_NUMBER, $urandom);
      pins();
      access(1'b0, `SCP_IDX_ONE_CONFIG, 32'h0);
   end
   $display("test pin control done");
   // Second reset in mid-run restores every default
   do_reset();
   foreach (idxs[k])
      access(1'b0, idxs[k], 32'h0);
   pins();
   $display("test second reset done");
   tally_and_finish();
end

endmodule

`default_nettype wire
